// >>> hw/s3e_regs.svh
// Register map, field layout, reset values and fixed constants
// of the stereo spatial enhancer. Definitions only.
`ifndef S3E_REGS_SVH
`define S3E_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define S3E_ADDR_W        12
`define S3E_OFS_LEVEL     12'h000
`define S3E_OFS_CTRL      12'h004
`define S3E_OFS_STAT      12'h008

// ****************************************
// Field positions
// ****************************************
`define S3E_WIDTH_LSB     0
`define S3E_WIDTH_MSB     3
`define S3E_CENTRE_LSB    4
`define S3E_CENTRE_MSB    7
`define S3E_EN_BIT        0
`define S3E_MONO_BIT      1
`define S3E_STAT_BUSY     0
`define S3E_STAT_CNT_LSB  16
`define S3E_STAT_CNT_MSB  31

// ****************************************
// Reset values
// ****************************************
`define S3E_LEVEL_RST     8'h83
`define S3E_CTRL_RST      2'h0

// ****************************************
// Gain and filter constants
// ****************************************
`define S3E_WIDTH_OFF     4'hF
`define S3E_MONO_WIDTH    4'h3
`define S3E_MONO_CENTRE   4'h8
`define S3E_LP_SHIFT      3
`define S3E_QUAD_SHIFT    1
`define S3E_Q_SHIFT       15

`endif

// >>> hw/s3e_pkg.sv
// Types shared by the stereo spatial enhancer.
// Assumes 16-bit signed PCM samples.
`default_nettype none

package s3e_pkg;

    // ****************************************
    // Sample pair
    // ****************************************
    typedef struct packed {
        logic signed [15:0] left;
        logic signed [15:0] right;
    } s3e_stereo_t;

    // ****************************************
    // Pipeline states
    // ****************************************
    typedef enum logic [2:0] {
        S3E_IDLE  = 3'b000,
        S3E_SYNTH = 3'b001,
        S3E_SPLIT = 3'b010,
        S3E_FILT  = 3'b011,
        S3E_MIX   = 3'b100,
        S3E_OUT   = 3'b101
    } s3e_state_t;

endpackage

`default_nettype wire

// >>> hw/s3e_enhancer.sv
// Stereo spatial enhancer: sum/difference processing with APB registers.
// Assumes the sample stream comes from logic on clk_i; one sample at a time.
//
// Operation
// - Form L+R and L-R from the incoming pair for separate processing.
// - Pass L-R through a corrective filter giving a processed difference.
// - The 4-bit width field sets the gain of the processed difference, added to the left output and subtracted from the right.
// - At the lowest width setting no processed difference is added.
// - The 4-bit centre field sets the gain of L+R added to both outputs.
// - Width code 0011 means -4.5 dB, the suggested starting width.
// - Centre code 1000 means -12.0 dB, the suggested starting centre.
// - With the enable and mono bits both set the input is treated as mono and widened.
// - In mono mode two filter banks 90 degrees apart make lead and lag signals.
// - Lead and lag are dematrixed into synthetic left/right, then enhanced as stereo.
// - In mono mode fixed gains replace the width and centre fields.
`include "s3e_regs.svh"
`default_nettype none

module s3e_enhancer (
    input  wire logic                     clk_i,
    input  wire logic                     sys_rst_i,
    input  wire logic [`S3E_ADDR_W-1:0]   paddr_i,
    input  wire logic                     psel_i,
    input  wire logic                     penable_i,
    input  wire logic                     pwrite_i,
    input  wire logic [31:0]              pwdata_i,
    input  wire logic [3:0]               pstrb_i,
    output logic [31:0]                   prdata_o,
    output logic                          pready_o,
    output logic                          pslverr_o,
    input  wire logic                     in_valid_i,
    output logic                          in_ready_o,
    input  wire s3e_pkg::s3e_stereo_t     in_sample_i,
    output logic                          out_valid_o,
    input  wire logic                     out_ready_i,
    output s3e_pkg::s3e_stereo_t          out_sample_o
);

    // ****************************************
    // Helpers
    // ****************************************
    // Code k gives -1.5 dB * k, Q1.15
    function automatic logic [15:0] gain_lut(input logic [3:0] code);
        logic [15:0] g;
        unique case (code)
            4'h0: g = 16'h7FFF;
            4'h1: g = 16'h6BB3;
            4'h2: g = 16'h5A9D;
            4'h3: g = 16'h4C3E;
            4'h4: g = 16'h4027;
            4'h5: g = 16'h35FA;
            4'h6: g = 16'h2D6B;
            4'h7: g = 16'h2637;
            4'h8: g = 16'h2027;
            4'h9: g = 16'h1B0E;
            4'hA: g = 16'h16C3;
            4'hB: g = 16'h1327;
            4'hC: g = 16'h101D;
            4'hD: g = 16'h0D8F;
            4'hE: g = 16'h0B68;
            4'hF: g = 16'h0999;
        endcase
        return g;
    endfunction

    function automatic logic signed [18:0] mul_q15(
        input logic signed [18:0] x,
        input logic        [15:0] g
    );
        logic signed [35:0] p;
        p = 36'(x) * 36'($signed({1'b0, g}));
        return p[`S3E_Q_SHIFT+18:`S3E_Q_SHIFT];
    endfunction

    function automatic logic signed [15:0] sat16(input logic signed [21:0] v);
        logic signed [15:0] r;
        if (v > 22'sh007FFF)
        begin
            r = 16'sh7FFF;
        end
        else if (v < -22'sh008000)
        begin
            r = -16'sh8000;
        end
        else
        begin
            r = v[15:0];
        end
        return r;
    endfunction

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0]  level_q;
    logic [7:0]  level_d;
    logic [1:0]  ctrl_q;
    logic [1:0]  ctrl_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic        hit_level;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        wr_acc;
    logic        busy;

    s3e_pkg::s3e_state_t state_q;
    s3e_pkg::s3e_state_t state_d;

    logic [3:0] width_gain;
    logic [3:0] centre_gain;
    logic       enhance_enable;
    logic       mono_synth_enable;

    assign width_gain        = level_q[`S3E_WIDTH_MSB:`S3E_WIDTH_LSB];
    assign centre_gain       = level_q[`S3E_CENTRE_MSB:`S3E_CENTRE_LSB];
    assign enhance_enable    = ctrl_q[`S3E_EN_BIT];
    assign mono_synth_enable = ctrl_q[`S3E_MONO_BIT];

    assign hit_level = (paddr_i == `S3E_OFS_LEVEL);
    assign hit_ctrl  = (paddr_i == `S3E_OFS_CTRL);
    assign hit_stat  = (paddr_i == `S3E_OFS_STAT);
    assign wr_acc    = psel_i && penable_i && pwrite_i && pstrb_i[0];
    assign busy      = (state_q != s3e_pkg::S3E_IDLE);

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !(hit_level || hit_ctrl || hit_stat);
    assign prdata_o  = prdata_q;

    always_comb
    begin
        level_d  = level_q;
        ctrl_d   = ctrl_q;
        prdata_d = prdata_q;
        if (wr_acc && hit_level)
        begin
            level_d = pwdata_i[7:0];
        end
        if (wr_acc && hit_ctrl)
        begin
            ctrl_d = pwdata_i[1:0];
        end
        // Read data latched in setup so access needs no wait
        if (psel_i && !penable_i && !pwrite_i)
        begin
            prdata_d = 32'h0000_0000;
            if (hit_level)
            begin
                prdata_d[7:0] = level_q;
            end
            else if (hit_ctrl)
            begin
                prdata_d[1:0] = ctrl_q;
            end
            else if (hit_stat)
            begin
                prdata_d[`S3E_STAT_BUSY] = busy;
                prdata_d[`S3E_STAT_CNT_MSB:`S3E_STAT_CNT_LSB] = count_q;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            level_q  <= `S3E_LEVEL_RST;
            ctrl_q   <= `S3E_CTRL_RST;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            level_q  <= level_d;
            ctrl_q   <= ctrl_d;
            prdata_q <= prdata_d;
        end
    end

    // ****************************************
    // Sample pipeline
    // ****************************************
    s3e_pkg::s3e_stereo_t in_q;
    s3e_pkg::s3e_stereo_t in_d;
    s3e_pkg::s3e_stereo_t work_q;
    s3e_pkg::s3e_stereo_t work_d;
    s3e_pkg::s3e_stereo_t out_q;
    s3e_pkg::s3e_stereo_t out_d;
    logic signed [16:0] sum_q;
    logic signed [16:0] sum_d;
    logic signed [16:0] diff_q;
    logic signed [16:0] diff_d;
    logic signed [16:0] lp_q;
    logic signed [16:0] lp_d;
    logic signed [18:0] dp_q;
    logic signed [18:0] dp_d;
    logic signed [15:0] x1_q;
    logic signed [15:0] x1_d;
    logic signed [15:0] x2_q;
    logic signed [15:0] x2_d;
    logic               mode_en_q;
    logic               mode_en_d;
    logic               mode_mono_q;
    logic               mode_mono_d;

    logic signed [15:0] mono_x;
    logic signed [16:0] lag;
    logic signed [17:0] lp_err;
    logic [3:0]         w_code;
    logic [3:0]         c_code;
    logic signed [18:0] w_term;
    logic signed [18:0] c_term;
    logic signed [21:0] mix_l;
    logic signed [21:0] mix_r;

    assign in_ready_o   = (state_q == s3e_pkg::S3E_IDLE);
    assign out_valid_o  = (state_q == s3e_pkg::S3E_OUT);
    assign out_sample_o = out_q;

    always_comb
    begin
        state_d     = state_q;
        in_d        = in_q;
        work_d      = work_q;
        out_d       = out_q;
        sum_d       = sum_q;
        diff_d      = diff_q;
        lp_d        = lp_q;
        dp_d        = dp_q;
        x1_d        = x1_q;
        x2_d        = x2_q;
        count_d     = count_q;
        mode_en_d   = mode_en_q;
        mode_mono_d = mode_mono_q;
        mono_x      = 16'(({in_q.left[15], in_q.left} + {in_q.right[15], in_q.right}) >>> 1);
        lag         = 17'((18'(mono_x) - 18'(x2_q)) >>> `S3E_QUAD_SHIFT);
        lp_err      = 18'(diff_q) - 18'(lp_q);
        w_code      = mode_mono_q ? `S3E_MONO_WIDTH : width_gain;
        c_code      = mode_mono_q ? `S3E_MONO_CENTRE : centre_gain;
        w_term      = (w_code == `S3E_WIDTH_OFF) ? 19'sh00000
                    : mul_q15(dp_q, gain_lut(w_code));
        c_term      = mul_q15(19'(sum_q), gain_lut(c_code));
        mix_l       = 22'(work_q.left) + 22'(c_term) + 22'(w_term);
        mix_r       = 22'(work_q.right) + 22'(c_term) - 22'(w_term);
        unique case (state_q)
            s3e_pkg::S3E_IDLE:
            begin
                if (in_valid_i)
                begin
                    in_d        = in_sample_i;
                    mode_en_d   = enhance_enable;
                    mode_mono_d = enhance_enable && mono_synth_enable;
                    state_d     = s3e_pkg::S3E_SYNTH;
                end
            end
            s3e_pkg::S3E_SYNTH:
            begin
                if (mode_mono_q)
                begin
                    // Lead is the one-sample-delayed mono, lag its quadrature
                    work_d.left  = sat16(22'(x1_q) + 22'(lag));
                    work_d.right = sat16(22'(x1_q) - 22'(lag));
                    x2_d         = x1_q;
                    x1_d         = mono_x;
                end
                else
                begin
                    work_d = in_q;
                end
                state_d = s3e_pkg::S3E_SPLIT;
            end
            s3e_pkg::S3E_SPLIT:
            begin
                sum_d   = 17'(work_q.left) + 17'(work_q.right);
                diff_d  = 17'(work_q.left) - 17'(work_q.right);
                state_d = s3e_pkg::S3E_FILT;
            end
            s3e_pkg::S3E_FILT:
            begin
                // Lift content above the low-pass corner of the difference
                lp_d    = 17'(18'(lp_q) + (lp_err >>> `S3E_LP_SHIFT));
                dp_d    = 19'(diff_q) + 19'(diff_q) - 19'(lp_q);
                state_d = s3e_pkg::S3E_MIX;
            end
            s3e_pkg::S3E_MIX:
            begin
                if (mode_en_q)
                begin
                    out_d.left  = sat16(mix_l);
                    out_d.right = sat16(mix_r);
                end
                else
                begin
                    out_d = in_q;
                end
                state_d = s3e_pkg::S3E_OUT;
            end
            s3e_pkg::S3E_OUT:
            begin
                if (out_ready_i)
                begin
                    count_d = count_q + 16'h0001;
                    state_d = s3e_pkg::S3E_IDLE;
                end
            end
            default:
            begin
                state_d = s3e_pkg::S3E_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_q     <= s3e_pkg::S3E_IDLE;
            in_q        <= 32'h0000_0000;
            work_q      <= 32'h0000_0000;
            out_q       <= 32'h0000_0000;
            sum_q       <= 17'sh00000;
            diff_q      <= 17'sh00000;
            lp_q        <= 17'sh00000;
            dp_q        <= 19'sh00000;
            x1_q        <= 16'sh0000;
            x2_q        <= 16'sh0000;
            count_q     <= 16'h0000;
            mode_en_q   <= 1'b0;
            mode_mono_q <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            in_q        <= in_d;
            work_q      <= work_d;
            out_q       <= out_d;
            sum_q       <= sum_d;
            diff_q      <= diff_d;
            lp_q        <= lp_d;
            dp_q        <= dp_d;
            x1_q        <= x1_d;
            x2_q        <= x2_d;
            count_q     <= count_d;
            mode_en_q   <= mode_en_d;
            mode_mono_q <= mode_mono_d;
        end
    end

endmodule

`default_nettype wire

// >>> testbench/s3e_enhancer_assertions.sv
// Port-level checks of the enhancer: APB answer and stream handshake.
// Assumes zero-wait APB and the five-cycle sample pipeline.
`include "s3e_regs.svh"
`default_nettype none

module s3e_enhancer_assertions (
    input wire logic                 clk_i,
    input wire logic                 sys_rst_i,
    input wire logic [11:0]          paddr_i,
    input wire logic                 psel_i,
    input wire logic                 penable_i,
    input wire logic                 pwrite_i,
    input wire logic [31:0]          pwdata_i,
    input wire logic [3:0]           pstrb_i,
    input wire logic [31:0]          prdata_o,
    input wire logic                 pready_o,
    input wire logic                 pslverr_o,
    input wire logic                 in_valid_i,
    input wire logic                 in_ready_o,
    input wire s3e_pkg::s3e_stereo_t in_sample_i,
    input wire logic                 out_valid_o,
    input wire logic                 out_ready_i,
    input wire s3e_pkg::s3e_stereo_t out_sample_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic acc;
    logic bad;
    logic en_q;
    assign acc = psel_i && penable_i;
    assign bad = !(paddr_i == `S3E_OFS_LEVEL || paddr_i == `S3E_OFS_CTRL || paddr_i == `S3E_OFS_STAT);

    // Shadow of the enable bit, tracked from bus writes
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            en_q <= 1'b0;
        end
        else if (acc && pwrite_i && pstrb_i[0] && paddr_i == `S3E_OFS_CTRL)
        begin
            en_q <= pwdata_i[`S3E_EN_BIT];
        end
    end

    a_bypass_exact: assert property (in_valid_i && in_ready_o && !en_q |->
        ##5 out_sample_o == $past(in_sample_i, 5)) else $error("bypass sample altered");

    a_ready_high: assert property (pready_o) else $error("pready low");
    a_err_unmapped: assert property (acc && bad |-> pslverr_o) else $error("no slave error");
    a_err_spurious: assert property (!(acc && bad) |-> !pslverr_o) else $error("stray slave error");
    a_unmap_zero: assert property (acc && bad && !pwrite_i |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_out_latency: assert property (in_valid_i && in_ready_o |=> !out_valid_o [*4] ##1 out_valid_o)
        else $error("output latency wrong");
    a_out_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_sample_o))
        else $error("output not held");
    a_out_release: assert property (out_valid_o && out_ready_i |=> !out_valid_o && in_ready_o)
        else $error("output not released");
    a_busy_refuse: assert property (out_valid_o |-> !in_ready_o) else $error("ready while busy");
endmodule

bind s3e_enhancer s3e_enhancer_assertions i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .in_sample_i(in_sample_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .out_sample_o(out_sample_o));

`default_nettype wire

// >>> testbench/s3e_dac_model.sv
// DAC-path sink model taking processed samples, with optional stalls.
// Assumes the enhancer's valid/ready output stream on clk_i.
`default_nettype none

module s3e_dac_model (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 slow_i,
    input  wire logic                 valid_i,
    input  wire s3e_pkg::s3e_stereo_t sample_i,
    output logic                      ready_o,
    output logic [15:0]               cnt_o,
    output s3e_pkg::s3e_stereo_t      data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] ph_q;
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ph_q <= 2'h0;
            cnt_o <= 16'h0;
            data_o <= '0;
        end
        else
        begin
            ph_q <= ph_q + 2'h1;
            if (valid_i && ready_o)
            begin
                cnt_o <= cnt_o + 16'h1;
                data_o <= sample_i;
            end
        end
    end
    // Stalls three cycles in four when slow
    assign ready_o = !slow_i || ph_q == 2'h3;
endmodule

`default_nettype wire

// >>> testbench/tb_s3e_enhancer.sv
// Self-checking bench of the enhancer: registers over APB, sample stream.
// Assumes the DAC sink model and the bound checker.
`include "s3e_regs.svh"
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("Error %s exp %0h got %0h", n, e, g); end end

module tb_s3e_enhancer;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [11:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic er;
    logic in_valid = 1'b0;
    logic in_ready;
    logic out_valid;
    logic out_ready;
    logic slow = 1'b0;
    logic [15:0] cnt;
    logic signed [15:0] pv;
    s3e_pkg::s3e_stereo_t in_s = '0;
    s3e_pkg::s3e_stereo_t out_s, dac, s, r;
    s3e_pkg::s3e_stereo_t seq [6];
    s3e_pkg::s3e_stereo_t mo [2][6];
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    int ex;

    s3e_enhancer i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .in_valid_i(in_valid), .in_ready_o(in_ready),
        .in_sample_i(in_s), .out_valid_o(out_valid), .out_ready_i(out_ready), .out_sample_o(out_s));
    s3e_dac_model i_dac (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow), .valid_i(out_valid),
        .sample_i(out_s), .ready_o(out_ready), .cnt_o(cnt), .data_o(dac));

    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    // Amplitude scaled by a gain given in dB
    function automatic int gained(input int x, input real db);
        return $rtoi(x * (10.0 ** (db / 20.0)));
    endfunction

    // Accepts a result within two codes of the expectation
    function automatic int snap(input int e, input int g);
        return (g >= e - 2 && g <= e + 2) ? e : g;
    endfunction

    task automatic conclude();
        $display("Checks: %0d, mismatches: %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            conclude();
        end
    end

    task automatic do_reset();
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (!pready);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic push(input s3e_pkg::s3e_stereo_t x, output s3e_pkg::s3e_stereo_t y);
        logic [15:0] g;
        g = cnt;
        slow <= 1'($urandom());
        in_valid <= 1'b1;
        in_s <= x;
        do @(posedge clk_i); while (!in_ready);
        in_valid <= 1'b0;
        while (cnt == g)
            @(posedge clk_i);
        y = dac;
    endtask

    initial
    begin
        void'($urandom(32'hBE23EFF2));
        do_reset();
        apb(1'b0, `S3E_OFS_LEVEL, 32'h0);
        `CHK("width", 4'h3, rd[3:0])
        `CHK("centre", 4'h8, rd[7:4])
        apb(1'b0, `S3E_OFS_CTRL, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        apb(1'b0, 12'h00C, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, `S3E_OFS_CTRL, 32'(m * 2));
            repeat (6)
            begin
                s = 32'($urandom());
                push(s, r);
                `CHK("bypass", s, r)
            end
        end
        apb(1'b0, `S3E_OFS_STAT, 32'h0);
        `CHK("delivered", 32'h000C_0000, rd)
        // Clean filter state: first difference sample sees Dp = 2D
        do_reset();
        apb(1'b1, `S3E_OFS_CTRL, 32'h1);
        s.left = 16'sd1000;
        s.right = -16'sd1000;
        push(s, r);
        ex = 1000 + gained(4000, -4.5);
        `CHK("width gain l", ex, snap(ex, r.left))
        `CHK("width gain r", -ex, snap(-ex, r.right))
        apb(1'b1, `S3E_OFS_LEVEL, 32'h8F);
        s.right = 16'sd1000;
        push(s, r);
        ex = 1000 + gained(2000, -12.0);
        `CHK("centre gain l", ex, snap(ex, r.left))
        `CHK("centre gain r", ex, snap(ex, r.right))
        // Width code F with L = -R: no sum, no difference
        apb(1'b1, `S3E_OFS_LEVEL, 32'h0F);
        apb(1'b1, `S3E_OFS_CTRL, 32'h1);
        repeat (6)
        begin
            s.left = 16'($urandom_range(8000)) - 16'sd4000;
            s.right = -s.left;
            push(s, r);
            `CHK("no width", s, r)
        end
        apb(1'b1, `S3E_OFS_LEVEL, 32'h83);
        repeat (6)
        begin
            s.left = 16'($urandom_range(4000, 1000));
            s.right = -s.left;
            push(s, r);
            `CHK("width sym", -r.left, r.right)
            `CHK("width adds", 1'b1, r.left != s.left)
        end
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, `S3E_OFS_LEVEL, 32'(c * 16 + 15));
            s = {16'sd2000, 16'sd2000};
            push(s, r);
            `CHK("centre sym", r.left, r.right)
            `CHK("centre step", 1'b1, r.left > s.left && (c == 0 || r.left < pv))
            pv = r.left;
        end
        // Same mono stream under opposite level settings
        for (int k = 0; k < 2; k++)
        begin
            do_reset();
            apb(1'b1, `S3E_OFS_LEVEL, k != 0 ? 32'hFF : 32'h00);
            apb(1'b1, `S3E_OFS_CTRL, 32'h3);
            for (int i = 0; i < 6; i++)
            begin
                if (k == 0)
                    seq[i] = i == 0 ? 32'h03E8_03E8 : 32'($urandom());
                push(seq[i], mo[k][i]);
            end
        end
        `CHK("mono split", 1'b1, mo[0][0].left != mo[0][0].right)
        for (int i = 0; i < 6; i++)
            `CHK("mono fixed", mo[0][i], mo[1][i])
        conclude();
    end
endmodule

`default_nettype wire
